// ---- hw/cph_defs.vh ----
`ifndef CPH_DEFS_VH
`define CPH_DEFS_VH

// ****************************************************************
// Clock and timing figures
// ****************************************************************
// Core clock rate in MHz (40 ns period)
`define CPH_CLK_MHZ        25
// Startup to attention, entering application, in us (1.1 ms)
`define CPH_T_APP_US       1100
// Startup to attention, entering bootloader, in us
`define CPH_T_BOOT_US      330
// Attention release after last data rise, least, in us (1.0 ms)
`define CPH_T_REL_MIN_US   1000
// Attention release after last data rise, most, in us (4.3 ms)
`define CPH_T_REL_MAX_US   4300
// Attention after an oversized transaction, least, in us
`define CPH_T_ERR_US       223
// Attention after wake request, most, in us (300 ms)
`define CPH_T_WAKE_MAX_US  300000
// Attention release after wake release, most, in us
`define CPH_T_WAKE_REL_US  25

// ****************************************************************
// Frame fields
// ****************************************************************
`define CPH_CMD_BOOT_FRAME 8'hfd
`define CPH_CMD_EZ_FRAME   8'hfe
`define CPH_LEN_MAX        8'h85
`define CPH_FRAME_OVHD     8'h03
`define CPH_IDX_CMD        8'h00
`define CPH_IDX_LEN        8'h01
`define CPH_BIT_LAST       3'h7
`define CPH_TX_IDLE        8'hff

// ****************************************************************
// Error codes
// ****************************************************************
`define CPH_ERR_NONE       2'h0
`define CPH_ERR_OVERSIZE   2'h1
`define CPH_ERR_ABORT      2'h2

`endif

// ---- hw/cph_handshake.v ----
`timescale 1ns/1ps
`include "cph_defs.vh"
// Contract
// - After reset with wake released, assert attention once application ready; code asserts after APP_CYC cycles, app_ready_i not checked in ST_BOOT.
// - Leaving reset with wake held, enter bootloader, assert attention.
// - Release attention 1.0 to 4.3 ms after last command data rise.
// - If attention still low at response, release 1.0-4.3 after data.
// - After oversize, assert attention no sooner than 223 us after select.
// - On wake, leave sleep, finish work, then assert attention.
// - Assert attention within 300 ms of wake request asserting.
// - Release attention within 25 us of wake release.
// - Later attention changes are ordinary callback events.
// - Already awake device runs the same handshake without side effect.
// - Length byte above 133 is oversized; drop command, abort.
// - After oversize or abort, assert attention once select idle.
module cph_handshake #(
    parameter CNT_W         = 23,
    parameter CLK_MHZ       = `CPH_CLK_MHZ,
    parameter APP_CYC       = `CPH_T_APP_US * `CPH_CLK_MHZ,
    parameter BOOT_CYC      = `CPH_T_BOOT_US * `CPH_CLK_MHZ,
    parameter REL_CYC       = `CPH_T_REL_MIN_US * `CPH_CLK_MHZ,
    parameter ERR_CYC       = `CPH_T_ERR_US * `CPH_CLK_MHZ,
    parameter WAKE_MAX_CYC  = `CPH_T_WAKE_MAX_US * `CPH_CLK_MHZ
) (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire       coprocessor_reset_line_n_i,
    input  wire       wake_request_line_n_i,
    input  wire       target_select_line_n_i,
    input  wire       spi_sclk_i,
    input  wire       spi_mosi_i,
    output wire       spi_miso_o,
    output wire       spi_miso_oe_n_o,
    output wire       host_attention_line_n_o,
    input  wire       app_ready_i,
    input  wire       attn_req_i,
    input  wire [7:0] tx_data_i,
    input  wire       tx_valid_i,
    output wire       tx_ready_o,
    output wire [7:0] rx_data_o,
    output wire       rx_valid_o,
    input  wire       rx_ready_i,
    output wire       boot_mode_o,
    output wire [1:0] err_code_o
);

    // ************************************************************
    // States and counts
    // ************************************************************
    localparam [4:0] ST_BOOT = 5'h01;
    localparam [4:0] ST_IDLE = 5'h02;
    localparam [4:0] ST_WAKE = 5'h04;
    localparam [4:0] ST_ATTN = 5'h08;
    localparam [4:0] ST_ERRW = 5'h10;

    localparam [CNT_W-1:0] APP_LIM  = APP_CYC;
    localparam [CNT_W-1:0] BOOT_LIM = BOOT_CYC;
    localparam [CNT_W-1:0] REL_LIM  = REL_CYC;
    localparam [CNT_W-1:0] ERR_LIM  = ERR_CYC;
    localparam [CNT_W-1:0] WAKE_LIM = WAKE_MAX_CYC - CLK_MHZ;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    // Bit order: 4 reset, 3 wake, 2 select, 1 sclk, 0 mosi
    reg  [4:0] sync1_r;
    reg  [4:0] sync2_r;
    reg  [4:0] prev_r;
    wire       corst_n   = sync2_r[4];
    wire       wake_n    = sync2_r[3];
    wire       sel_n     = sync2_r[2];
    wire       sclk_rise = sync2_r[1] & ~prev_r[1];
    wire       sclk_fall = ~sync2_r[1] & prev_r[1];
    wire       mosi_rise = sync2_r[0] & ~prev_r[0] & ~sel_n;
    wire       wake_fall = ~wake_n & prev_r[3];
    wire       sel_start = ~sel_n & prev_r[2];
    wire       sel_end   = sel_n & ~prev_r[2];

    // Two flops per pin, third stage for edges
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // Idle levels: pins high, link clock and data low
            sync1_r <= 5'h1c;
            sync2_r <= 5'h1c;
            prev_r  <= 5'h1c;
        end else begin
            sync1_r <= {coprocessor_reset_line_n_i, wake_request_line_n_i,
                        target_select_line_n_i, spi_sclk_i, spi_mosi_i};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // ************************************************************
    // SPI target shifter and frame check
    // ************************************************************
    reg  [2:0] bit_cnt_r;
    reg  [7:0] rx_sh_r;
    reg  [7:0] tx_sh_r;
    reg        miso_r;
    reg        miso_oe_n_r;
    reg        tx_ready_r;
    reg  [7:0] byte_idx_r;
    reg  [7:0] need_r;
    reg        has_len_r;
    reg        oversize_r;
    reg        overflow_r;
    reg        data_rise_r;
    wire [7:0] rx_byte   = {rx_sh_r[6:0], sync2_r[0]};
    wire       byte_done = sclk_rise & ~sel_n & (bit_cnt_r == `CPH_BIT_LAST);
    wire       push      = byte_done & ~oversize_r;
    wire       push_ok;
    wire       frame_bad = oversize_r | overflow_r | (bit_cnt_r != 3'h0) |
                           (has_len_r & (byte_idx_r < need_r));
    wire       tx_load   = sel_start | byte_done;

    // Bit shifting on sampled clock edges, mode 0
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bit_cnt_r   <= 3'h0;
            rx_sh_r     <= 8'h00;
            tx_sh_r     <= `CPH_TX_IDLE;
            miso_r      <= 1'b1;
            miso_oe_n_r <= 1'b1;
            tx_ready_r  <= 1'b0;
            data_rise_r <= 1'b0;
        end else begin
            miso_oe_n_r <= sel_n;
            tx_ready_r  <= tx_load & tx_valid_i;
            data_rise_r <= mosi_rise | (sclk_fall & ~sel_n &
                                        tx_sh_r[7] & ~miso_r);
            if (sel_start)
                bit_cnt_r <= 3'h0;
            else if (sclk_rise & ~sel_n) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                rx_sh_r   <= rx_byte;
            end
            // First bit stands from select fall, mode 0
            if (sel_start) begin
                tx_sh_r <= tx_valid_i ? {tx_data_i[6:0], 1'b1} : `CPH_TX_IDLE;
                miso_r  <= ~tx_valid_i | tx_data_i[7];
            end else if (byte_done)
                tx_sh_r <= tx_valid_i ? tx_data_i : `CPH_TX_IDLE;
            else if (sclk_fall & ~sel_n) begin
                miso_r  <= tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b1};
            end
        end
    end

    // Byte index, length check, overflow
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            byte_idx_r <= 8'h00;
            need_r     <= 8'h00;
            has_len_r  <= 1'b0;
            oversize_r <= 1'b0;
            overflow_r <= 1'b0;
        end else if (sel_start) begin
            byte_idx_r <= 8'h00;
            has_len_r  <= 1'b0;
            oversize_r <= 1'b0;
            overflow_r <= 1'b0;
        end else if (byte_done) begin
            byte_idx_r <= byte_idx_r + 8'h01;
            if (byte_idx_r == `CPH_IDX_CMD)
                has_len_r <= (rx_byte == `CPH_CMD_BOOT_FRAME) |
                             (rx_byte == `CPH_CMD_EZ_FRAME);
            if (byte_idx_r == `CPH_IDX_LEN && has_len_r) begin
                need_r <= rx_byte + `CPH_FRAME_OVHD;
                if (rx_byte > `CPH_LEN_MAX)
                    oversize_r <= 1'b1;
            end
            if (push & ~push_ok)
                overflow_r <= 1'b1;
        end
    end

    // ************************************************************
    // Two-entry receive buffer
    // ************************************************************
    reg  [7:0] buf0_r;
    reg  [7:0] buf1_r;
    reg        vld0_r;
    reg        vld1_r;
    wire       pop = vld0_r & rx_ready_i;
    assign push_ok = ~vld1_r | pop;

    // Entry 0 faces the user; entry 1 backs it up
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            buf0_r <= 8'h00;
            buf1_r <= 8'h00;
            vld0_r <= 1'b0;
            vld1_r <= 1'b0;
        end else begin
            if (pop) begin
                buf0_r <= vld1_r ? buf1_r : rx_byte;
                vld0_r <= vld1_r | (push & push_ok);
                vld1_r <= vld1_r & push;
                if (vld1_r)
                    buf1_r <= rx_byte;
            end else if (push & push_ok) begin
                if (vld0_r) begin
                    buf1_r <= rx_byte;
                    vld1_r <= 1'b1;
                end else begin
                    buf0_r <= rx_byte;
                    vld0_r <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Attention sequencer
    // ************************************************************
    reg  [4:0]       state_r;
    reg  [4:0]       state_nxt;
    reg  [CNT_W-1:0] tmr_r;
    reg  [CNT_W-1:0] rel_cnt_r;
    reg              rel_pend_r;
    reg              wake_hs_r;
    reg              boot_pend_r;
    reg              boot_mode_r;
    reg              attn_n_r;
    reg  [1:0]       err_r;
    wire             frame_err = sel_end & frame_bad;

    // Next state
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT: begin
                if (~boot_pend_r &&
                    tmr_r >= (boot_mode_r ? BOOT_LIM : APP_LIM))
                    state_nxt = ST_ATTN;
            end
            ST_IDLE: begin
                if (frame_err)
                    state_nxt = ST_ERRW;
                else if (wake_fall)
                    state_nxt = ST_WAKE;
                else if (attn_req_i)
                    state_nxt = ST_ATTN;
            end
            ST_WAKE: begin
                if (app_ready_i || tmr_r >= WAKE_LIM)
                    state_nxt = ST_ATTN;
            end
            ST_ATTN: begin
                if (frame_err)
                    state_nxt = ST_ERRW;
                else if (wake_hs_r && wake_n)
                    state_nxt = ST_IDLE;
                else if (rel_pend_r && sel_n && rel_cnt_r >= REL_LIM)
                    state_nxt = ST_IDLE;
            end
            ST_ERRW: begin
                if (tmr_r >= ERR_LIM)
                    state_nxt = ST_ATTN;
            end
            default: state_nxt = ST_BOOT;
        endcase
    end

    // State, timers and outputs
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= ST_BOOT;
            tmr_r       <= {CNT_W{1'b0}};
            rel_cnt_r   <= {CNT_W{1'b0}};
            rel_pend_r  <= 1'b0;
            wake_hs_r   <= 1'b0;
            boot_pend_r <= 1'b1;
            boot_mode_r <= 1'b0;
            attn_n_r    <= 1'b1;
            err_r       <= `CPH_ERR_NONE;
        end else if (~corst_n) begin
            // Reset pin held: wait for release
            state_r     <= ST_BOOT;
            tmr_r       <= {CNT_W{1'b0}};
            rel_pend_r  <= 1'b0;
            wake_hs_r   <= 1'b0;
            boot_pend_r <= 1'b1;
            attn_n_r    <= 1'b1;
            err_r       <= `CPH_ERR_NONE;
        end else begin
            state_r  <= state_nxt;
            attn_n_r <= (state_nxt != ST_ATTN);
            // Wake level caught at reset release
            if (boot_pend_r) begin
                boot_pend_r <= 1'b0;
                boot_mode_r <= ~wake_n;
            end
            // Timer restarts on every state change
            if (state_nxt != state_r)
                tmr_r <= {CNT_W{1'b0}};
            else if (tmr_r != {CNT_W{1'b1}})
                tmr_r <= tmr_r + {{(CNT_W-1){1'b0}}, 1'b1};
            // Time since last rising edge of data
            if (data_rise_r)
                rel_cnt_r <= {CNT_W{1'b0}};
            else if (rel_cnt_r != {CNT_W{1'b1}})
                rel_cnt_r <= rel_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            // Release armed by a finished transaction
            if (state_nxt != ST_ATTN)
                rel_pend_r <= 1'b0;
            else if (sel_end)
                rel_pend_r <= 1'b1;
            // Handshake flag kept until state leaves ST_ATTN
            if (state_r == ST_WAKE && state_nxt == ST_ATTN)
                wake_hs_r <= 1'b1;
            else if (state_nxt != ST_ATTN)
                wake_hs_r <= 1'b0;
            // First error kept, cleared by the frame that reports it
            if (sel_end) begin
                if (err_r != `CPH_ERR_NONE)
                    err_r <= `CPH_ERR_NONE;
                else if (oversize_r)
                    err_r <= `CPH_ERR_OVERSIZE;
                else if (frame_bad)
                    err_r <= `CPH_ERR_ABORT;
            end
        end
    end

    // ************************************************************
    // Output drive
    // ************************************************************
    assign host_attention_line_n_o = attn_n_r;
    assign spi_miso_o              = miso_r;
    assign spi_miso_oe_n_o         = miso_oe_n_r;
    assign tx_ready_o              = tx_ready_r;
    assign rx_data_o               = buf0_r;
    assign rx_valid_o              = vld0_r;
    assign boot_mode_o             = boot_mode_r;
    assign err_code_o              = err_r;

endmodule

// ---- sim/cph_handshake_asserts.sv ----
`timescale 1ns/1ps
// ****
// Handshake timing checker
// ****
module cph_handshake_asserts #(
    parameter int APP_CYC      = 50,
    parameter int BOOT_CYC     = 30,
    parameter int REL_CYC      = 40,
    parameter int ERR_CYC      = 20,
    parameter int WAKE_MAX_CYC = 200
) (
    input wire       mclk_i,
    input wire       rst_i,
    input wire       coprocessor_reset_line_n_i,
    input wire       wake_request_line_n_i,
    input wire       target_select_line_n_i,
    input wire       spi_sclk_i,
    input wire       spi_mosi_i,
    input wire       spi_miso_o,
    input wire       spi_miso_oe_n_o,
    input wire       host_attention_line_n_o,
    input wire       app_ready_i,
    input wire       attn_req_i,
    input wire [7:0] tx_data_i,
    input wire       tx_valid_i,
    input wire       tx_ready_o,
    input wire [7:0] rx_data_o,
    input wire       rx_valid_o,
    input wire       rx_ready_i,
    input wire       boot_mode_o,
    input wire [1:0] err_code_o
);
    wire        attn  = host_attention_line_n_o;
    wire        wake  = wake_request_line_n_i;
    wire        sel   = target_select_line_n_i;
    wire        pin   = coprocessor_reset_line_n_i;
    wire [15:0] lim_w = boot_mode_o ? BOOT_CYC : APP_CYC;
    logic       wk_r;
    int         pin_r, edg_r, sel_r;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Wake handshake flag and saturating cycle counters
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wk_r  <= 1'b0;
            pin_r <= 0;
            edg_r <= 0;
            sel_r <= 0;
        end else begin
            if ($fell(wake) && attn && pin)
                wk_r <= 1'b1;
            else if ($rose(attn))
                wk_r <= 1'b0;
            pin_r <= pin ? pin_r + (pin_r < 9999) : 0;
            edg_r <= (($rose(spi_mosi_i) || $rose(spi_miso_o)) && !sel) ? 0
                     : edg_r + (edg_r < 9999);
            sel_r <= $rose(sel) ? 0 : sel_r + (sel_r < 9999);
        end
    end

    chk_start_delay : assert property (
        $fell(attn) && pin_r < APP_CYC + 8 |-> pin_r >= lim_w
        && pin_r <= lim_w + 6) else $error("startup delay off");
    chk_boot_latch : assert property (
        pin_r > 6 |-> $stable(boot_mode_o)) else $error("boot mode moved");
    chk_release_min : assert property (
        $rose(attn) && !wk_r && pin && err_code_o == 2'h0 |-> edg_r >= REL_CYC)
        else $error("attention released early");
    chk_error_delay : assert property (
        $fell(attn) && err_code_o != 2'h0 |-> sel_r >= ERR_CYC)
        else $error("error attention early");
    chk_wake_bound : assert property (
        $fell(wake) && attn && pin |-> ##[1:WAKE_MAX_CYC] !attn)
        else $error("no attention after wake");
    chk_wake_release : assert property (
        wk_r && $rose(wake) |-> ##[1:625] attn)
        else $error("attention held after wake release");
    chk_rx_hold : assert property (
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
        else $error("receive word lost");
    chk_pin_reset : assert property (
        !pin [*5] |-> attn) else $error("attention low in reset");
    chk_oe_follow : assert property (
        $stable(sel) [*5] |-> spi_miso_oe_n_o == sel)
        else $error("miso enable wrong");
    chk_tx_pulse : assert property (
        tx_ready_o |=> !tx_ready_o) else $error("tx ready too long");
endmodule

// ---- sim/cph_host_model.sv ----
`timescale 1ns/1ps
// ****
// Host controller model
// ****
module cph_host_model #(
    parameter int GAP_NS = 2000
) (
    input  wire  attn_n_i,
    input  wire  miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic sel_n_o,
    output logic wake_n_o,
    output logic rst_n_o
);
    logic [7:0] mo [0:3];
    logic [7:0] mi [0:3];

    // Idle pins, link clock stands still
    initial {sclk_o, mosi_o, sel_n_o, wake_n_o, rst_n_o} = 5'b00111;

    // One frame, mode 0, MSB first, off the core clock phase
    task automatic xfer(input int n);
        int i;
        int b;
        #7 sel_n_o = 1'b0;
        #320;
        for (i = 0; i < n; i++) begin
            for (b = 7; b >= 0; b--) begin
                mosi_o = mo[i][b];
                #160 mi[i][b] = miso_i;
                sclk_o = 1'b1;
                #160 sclk_o = 1'b0;
            end
        end
        #160 sel_n_o = 1'b1;
        mosi_o = !mosi_o; // Released line no longer shows last bit
        #GAP_NS;
    endtask

    // Wake handshake with bounded wait for attention
    task automatic wake(input int lim, output int c);
        c = 0;
        if (attn_n_i) begin
            wake_n_o = 1'b0;
            while (attn_n_i && c < lim) begin
                #40 c++;
            end
            wake_n_o = 1'b1;
        end
    endtask

    // Pin reset, wake held only when bootloader wanted
    task automatic pin_reset(input logic boot, output int c);
        c = 0;
        rst_n_o = 1'b0;
        wake_n_o = !boot;
        #400 rst_n_o = 1'b1;
        while (attn_n_i && c < 100) begin
            #40 c++;
        end
        wake_n_o = 1'b1;
    endtask
endmodule

// ---- sim/test_cph_handshake.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
    failures++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module test_cph_handshake;
    localparam int APP = 50, BOOT = 30, REL = 40, ERR = 20, WMAX = 200;
    logic       mclk_i, rst_i, app_ready_i, rx_ready_i, hold, attn_req_i;
    wire        coprocessor_reset_line_n_i, wake_request_line_n_i;
    wire        target_select_line_n_i, spi_sclk_i, spi_mosi_i;
    wire        spi_miso_o, spi_miso_oe_n_o, host_attention_line_n_o;
    wire        tx_ready_o, rx_valid_o, boot_mode_o;
    wire  [7:0] rx_data_o;
    wire  [1:0] err_code_o;
    wire        tx_valid_i = 1'b1;
    wire  [7:0] tx_data_i  = 8'h5a;
    logic [7:0] rxq [$];
    int         failures = 0, samples_checked = 0, cyc = 0, c;

    cph_handshake #(.APP_CYC(APP), .BOOT_CYC(BOOT), .REL_CYC(REL),
        .ERR_CYC(ERR), .WAKE_MAX_CYC(WMAX)) i_dut (.*);
    cph_host_model i_host (.attn_n_i(host_attention_line_n_o),
        .miso_i(spi_miso_o),
        .sclk_o(spi_sclk_i), .mosi_o(spi_mosi_i),
        .sel_n_o(target_select_line_n_i), .wake_n_o(wake_request_line_n_i),
        .rst_n_o(coprocessor_reset_line_n_i));

    // Core clock
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = !mclk_i;
    end

    // Receiver stalls half the time, collects words, cuts hangs
    always @(negedge mclk_i) rx_ready_i <= !hold && cyc[2];
    always @(posedge mclk_i) begin
        cyc++;
        if (rx_valid_o === 1'b1 && rx_ready_i)
            rxq.push_back(rx_data_o);
        if (cyc == 20000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wait_attn(input logic lvl, input int lim);
        c = 0;
        while (host_attention_line_n_o !== lvl && c < lim) begin
            @(negedge mclk_i);
            c++;
        end
    endtask

    task automatic frame(input logic [31:0] b);
        int i;
        for (i = 0; i < 4; i++)
            i_host.mo[i] = b[31-8*i -: 8];
        i_host.xfer(4);
        @(negedge mclk_i);
    endtask

    // Good frame: words in order, attention released after it
    task automatic t_frame();
        rxq.delete();
        frame(32'hfe0133a7);
        `CHK("rx words", 32'hfe0133a7, {rxq[0], rxq[1], rxq[2], rxq[3]})
        `CHK("miso words", 32'h5a5a5a5a, {i_host.mi[0], i_host.mi[1],
             i_host.mi[2], i_host.mi[3]})
        `CHK("released", 1'b1, host_attention_line_n_o)
        `CHK("no error", 2'h0, err_code_o)
        $display("test frame done");
    endtask

    // Wake handshake with ready after dly cycles
    task automatic t_wake(input int dly, input int lo, input int hi);
        int w;
        app_ready_i = (dly == 0);
        fork
            i_host.wake(WMAX + 20, w);
            begin
                repeat (dly) @(negedge mclk_i);
                `CHK("asleep", 1'b1, host_attention_line_n_o)
                app_ready_i = 1'b1;
            end
        join
        `CHK("wake time", 1'b1, w >= lo && w <= hi)
        wait_attn(1'b1, 700);
        `CHK("wake release", 1'b1, c <= 625)
        `CHK("side effect", 3'h0, {boot_mode_o, err_code_o})
        $display("test wake done");
    endtask

    // Faulty frame, then the frame that carries the report
    task automatic t_error(input logic [31:0] b, input logic [1:0] code);
        rxq.delete();
        frame(b);
        `CHK("err code", code, err_code_o)
        `CHK("alert", 1'b0, host_attention_line_n_o)
        if (hold) begin
            hold = 1'b0;
            repeat (20) @(negedge mclk_i);
            `CHK("kept words", 17'h1fe01, {rxq.size() == 2, rxq[0], rxq[1]})
        end
        frame(32'hfe0133a7);
        `CHK("err cleared", 2'h0, err_code_o)
        `CHK("idle", 1'b1, host_attention_line_n_o)
        $display("test error done");
    endtask

    // Callback event from idle, then a frame releases it
    task automatic t_event();
        attn_req_i = 1'b1;
        @(negedge mclk_i);
        attn_req_i = 1'b0;
        wait_attn(1'b0, 10);
        `CHK("event attn", 1'b1, c <= 2)
        frame(32'hfe0133a7);
        `CHK("event release", 1'b1, host_attention_line_n_o)
        $display("test event done");
    endtask

    // Pin reset into application or bootloader
    task automatic t_pin(input logic boot);
        i_host.pin_reset(boot, c);
        `CHK("pin start", 1'b1, c >= (boot ? BOOT : APP))
        `CHK("pin start max", 1'b1, c <= (boot ? BOOT : APP) + 6)
        `CHK("boot mode", boot, boot_mode_o)
        $display("test pin reset done");
    endtask

    initial begin
        rst_i = 1'b1;
        app_ready_i = 1'b1;
        attn_req_i = 1'b0;
        hold = 1'b0;
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        wait_attn(1'b0, APP + 20);
        `CHK("startup", 1'b1, c >= APP && c <= APP + 6)
        $display("test startup done");
        t_frame();
        t_wake(30, 30, 36);
        t_wake(0, 0, 6);
        t_wake(1000, WMAX - 30, WMAX);
        t_error(32'hfe860000, 2'h1);
        hold = 1'b1;
        t_error(32'hfe0133a7, 2'h2);
        t_event();
        t_pin(1'b0);
        t_pin(1'b1);
        wrap_up();
    end
endmodule

bind cph_handshake cph_handshake_asserts #(.APP_CYC(APP_CYC),
    .BOOT_CYC(BOOT_CYC), .REL_CYC(REL_CYC), .ERR_CYC(ERR_CYC),
    .WAKE_MAX_CYC(WAKE_MAX_CYC)) i_chk (.*);
